// ### tb_ufc_fifo_ctrl.sv
/*
 * Self-checking bench for the FIFO control block.
 * Assumes the counts come from ufc_fifo_model and a 50 MHz clock.
 */
module tb_ufc_fifo_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, hold_wr, ld;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rx_cnt, tx_cnt, rx_v, tx_v, rx_trig, tx_trig;
    logic fifo_en, rx_fl, tx_fl, rx_irq, tx_irq, irq;
    int fail_count, checks, c;
    logic [7:0] v;
    int rxt[4] = '{8, 16, 24, 28};
    int txt[4] = '{16, 8, 24, 30};
    ufc_fifo_ctrl #(.CNT_W(8)) ufc_fifo_ctrl_inst (.MCLK_I(clk),
        .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .RX_COUNT_I(rx_cnt), .TX_COUNT_I(tx_cnt),
        .TX_HOLD_WR_I(hold_wr), .FIFO_EN_O(fifo_en), .RX_FLUSH_O(rx_fl),
        .TX_FLUSH_O(tx_fl), .RX_TRIG_O(rx_trig), .TX_TRIG_O(tx_trig),
        .RX_READY_IRQ_O(rx_irq), .TX_EMPTY_IRQ_O(tx_irq), .IRQ_O(irq));
    ufc_fifo_model ufc_fifo_model_inst (.clk_i(clk), .rst_i(rst),
        .rx_flush_i(rx_fl), .tx_flush_i(tx_fl), .load_i(ld),
        .rx_load_i(rx_v), .tx_load_i(tx_v), .rx_count_o(rx_cnt),
        .tx_count_o(tx_cnt));
    ////////////////////////////////////////////////////////////////////////
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Bus and model helpers; reads sample the cycle after the strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask
    task automatic set_cnt(input logic [7:0] r, input logic [7:0] t);
        @(posedge clk);
        {ld, rx_v, tx_v} <= {1'b1, r, t};
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait on the sticky transmit interrupt
    task automatic wait_tx(input logic e);
        for (int n = 0; n < 4 && tx_irq !== e; n++) begin
            @(posedge clk);
            #1;
        end
        if (tx_irq !== e) begin
            fail_count++;
            $display("Error at %0t: tx interrupt wait ran out", $time);
            stop_test();
        end else begin
            chk(tx_irq, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, wr, rd, hold_wr, ld, addr, wdata, rx_v, tx_v} = '0;
        {fail_count, checks} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h8bf9));
        // Reset values of every register and output
        for (int k = 0; k < 8; k++) begin
            rd_reg(4'(k));
            chk(rdata, 8'h00);
        end
        chk({2'h0, fifo_en, irq, rx_fl, tx_fl, rx_irq, tx_irq}, 8'h00);
        chk(rx_trig, 8'h08);
        chk(tx_trig, 8'h10);
        $display("test reset values done");
        // Every trigger code with random low bits and receive fill counts
        for (int i = 0; i < 16; i++) begin
            v = {4'(i), 4'($urandom)};
            wr_reg(4'h0, v);
            chk({rx_fl, tx_fl, fifo_en}, {v[1], v[2], v[0]});
            chk(rx_trig, 8'(rxt[v[7:6]]));
            chk(tx_trig, 8'(txt[v[5:4]]));
            @(posedge clk);
            #1;
            chk({rx_fl, tx_fl}, 8'h00);
            rd_reg(4'h0);
            chk(rdata, v & 8'hf1);
            c = $urandom_range(31);
            set_cnt(8'(c), 8'h20);
            chk(rx_irq, v[0] && c >= rxt[v[7:6]]);
        end
        $display("test trigger decode done");
        // Reserved bit and an unmapped index
        wr_reg(4'h0, 8'h09);
        chk({rx_fl, tx_fl, fifo_en}, 8'h01);
        wr_reg(4'hf, 8'hff);
        rd_reg(4'hf);
        chk(rdata, 8'h00);
        rd_reg(4'h0);
        chk(rdata, 8'h01);
        $display("test reserved done");
        // Receive then transmit flush emptying the model's FIFOs
        set_cnt(8'd30, 8'd30);
        chk(rx_irq, 1'b1);
        wr_reg(4'h0, 8'h03);
        chk(rx_fl, 1'b1);
        @(posedge clk);
        #1;
        chk(rx_irq, 1'b0);
        wr_reg(4'h0, 8'h05);
        chk(tx_fl, 1'b1);
        wait_tx(1'b1);
        rd_reg(4'h0);
        chk(rdata, 8'h01);
        $display("test flush done");
        // Transmit empty: mask, status read, holding write, write one
        chk(irq, 1'b0);
        wr_reg(4'h6, 8'h02);
        chk(irq, 1'b1);
        set_cnt(8'h00, 8'd20);
        chk(tx_irq, 1'b1);
        rd_reg(4'h5);
        chk(rdata, 8'h02);
        wait_tx(1'b0);
        set_cnt(8'h00, 8'd5);
        wait_tx(1'b1);
        set_cnt(8'h00, 8'd20);
        @(posedge clk);
        hold_wr <= 1'b1;
        @(posedge clk);
        hold_wr <= 1'b0;
        #1;
        wait_tx(1'b0);
        set_cnt(8'h00, 8'd5);
        wait_tx(1'b1);
        wr_reg(4'h5, 8'h02);
        wait_tx(1'b0);
        chk(irq, 1'b0);
        wr_reg(4'h6, 8'h01);
        set_cnt(8'd30, 8'd20);
        chk(irq, 1'b1);
        rd_reg(4'h5);
        chk(rdata, 8'h01);
        set_cnt(8'd7, 8'd20);
        chk({rx_irq, irq}, 8'h00);
        $display("test interrupts done");
        // Any nonzero level register switches to the level registers
        for (int k = 1; k < 5; k++) begin
            wr_reg(4'(k), 8'h05);
            chk(rx_trig, (k == 1) ? 8'h05 : 8'h00);
            chk(tx_trig, (k == 2) ? 8'h05 : 8'h00);
            rd_reg(4'h7);
            chk(rdata, 8'h01);
            wr_reg(4'(k), 8'h00);
            chk(rx_trig, 8'h08);
        end
        $display("test level override done");
        stop_test();
    end
endmodule // tb_ufc_fifo_ctrl

// ### ufc_fifo_ctrl.sv
/*
 * UART FIFO control: enable, self-clearing flushes, trigger levels and
 * the receive-ready / transmit-empty interrupts.
 * Assumes the FIFO counts come from logic on the same clock and that the
 * tx holding write and status read strobes are one-cycle pulses.
 */
// Function
// R1: Bit 0 enables both FIFOs together.
// R2: Bit 1 flushes receive FIFO, self-clears.
// R3: Bit 2 flushes transmit FIFO, self-clears.
// R4: Enable and reset bits default to zero.
// R5: Bits 7:6 pick receive threshold, raise ready.
// R6: Receive decode: 8, 16, 24, 28 bytes.
// R7: Bits 5:4 pick transmit threshold, empty irq.
// R8: Transmit decode: 16, 8, 24, 30 bytes.
// R9: Nonzero level registers override 2-bit fields.
// R10: Receive ready drops below threshold at once.
// R11: Transmit empty clears on status read, write.
// R12: Flush finishes within one clock cycle.
// R13: Reserved bit 3 has no effect.
module ufc_fifo_ctrl #(
    parameter int CNT_W = 8
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [CNT_W-1:0] RX_COUNT_I,
    input wire logic [CNT_W-1:0] TX_COUNT_I,
    input wire logic TX_HOLD_WR_I,
    output logic FIFO_EN_O,
    output logic RX_FLUSH_O,
    output logic TX_FLUSH_O,
    output logic [7:0] RX_TRIG_O,
    output logic [7:0] TX_TRIG_O,
    output logic RX_READY_IRQ_O,
    output logic TX_EMPTY_IRQ_O,
    output logic IRQ_O
);

    // Counts must hold the deepest 32-byte threshold and fit 8 bits
    if (CNT_W < 5 || CNT_W > 8) begin : g_cnt_w_check
        $error("CNT_W must be 5 to 8");
    end

    // All checks below run on the one clock and sleep during reset
    default clocking cb_mclk @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    ////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic [7:0] rx_decode(input logic [1:0] sel);
        unique case (sel)
            2'h0: rx_decode = ufc_pkg::RX_TRIG_0;
            2'h1: rx_decode = ufc_pkg::RX_TRIG_1;
            2'h2: rx_decode = ufc_pkg::RX_TRIG_2;
            2'h3: rx_decode = ufc_pkg::RX_TRIG_3;
        endcase
    endfunction

    function automatic logic [7:0] tx_decode(input logic [1:0] sel);
        unique case (sel)
            2'h0: tx_decode = ufc_pkg::TX_TRIG_0;
            2'h1: tx_decode = ufc_pkg::TX_TRIG_1;
            2'h2: tx_decode = ufc_pkg::TX_TRIG_2;
            2'h3: tx_decode = ufc_pkg::TX_TRIG_3;
        endcase
    endfunction

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    logic [7:0] fifo_ctrl_q;
    logic [7:0] rx_lvl_q;
    logic [7:0] tx_lvl_q;
    logic [7:0] flow_lo_q;
    logic [7:0] flow_hi_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic rx_flush_q;
    logic tx_flush_q;
    logic [7:0] rdata_q;
    logic tx_empty_prev_q;
    logic [7:0] rx_trig;
    logic [7:0] tx_trig;
    logic override;
    logic [7:0] rx_cnt;
    logic [7:0] tx_cnt;
    logic rx_ready;
    logic tx_below;
    logic wr_fc;
    logic rd_stat;

    assign wr_fc = WR_I && hit(ADDR_I, ufc_pkg::OFS_FIFO_CTRL);
    assign rd_stat = RD_I && hit(ADDR_I, ufc_pkg::OFS_IRQ_STAT);
    assign rx_cnt = 8'(RX_COUNT_I);
    assign tx_cnt = 8'(TX_COUNT_I);

    ////////////////////////////////////////////////////////////////////
    // Fifo control register; flush bits never stored so they read 0
    // R4: zero at reset
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            fifo_ctrl_q <= ufc_pkg::FIFO_CTRL_RST;
        end else if (wr_fc) begin
            // R13: reserved bit 3 dropped
            fifo_ctrl_q <= {WDATA_I[7:4], 4'h0} | {7'h00, WDATA_I[0]};
        end
    end

    // Level registers written by software
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_lvl_q <= ufc_pkg::LVL_RST;
            tx_lvl_q <= ufc_pkg::LVL_RST;
            flow_lo_q <= ufc_pkg::LVL_RST;
            flow_hi_q <= ufc_pkg::LVL_RST;
        end else if (WR_I) begin
            if (hit(ADDR_I, ufc_pkg::OFS_RX_LVL)) begin
                rx_lvl_q <= WDATA_I;
            end
            if (hit(ADDR_I, ufc_pkg::OFS_TX_LVL)) begin
                tx_lvl_q <= WDATA_I;
            end
            if (hit(ADDR_I, ufc_pkg::OFS_FLOW_LO)) begin
                flow_lo_q <= WDATA_I;
            end
            if (hit(ADDR_I, ufc_pkg::OFS_FLOW_HI)) begin
                flow_hi_q <= WDATA_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flush pulses, one cycle after the write
    // R2: receive flush pulse
    // R3: transmit flush pulse
    // R12: done in one cycle
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_flush_q <= 1'b0;
            tx_flush_q <= 1'b0;
        end else begin
            rx_flush_q <= wr_fc && WDATA_I[ufc_pkg::FC_RX_RST];
            tx_flush_q <= wr_fc && WDATA_I[ufc_pkg::FC_TX_RST];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Threshold selection
    // R9: override by level registers
    assign override = |{rx_lvl_q, tx_lvl_q, flow_lo_q, flow_hi_q};
    // R6: receive decode
    // R8: transmit decode
    always_comb begin
        if (override) begin
            rx_trig = rx_lvl_q;
            tx_trig = tx_lvl_q;
        end else begin
            rx_trig = rx_decode(fifo_ctrl_q[ufc_pkg::FC_RX_LVL_LO +: 2]);
            tx_trig = tx_decode(fifo_ctrl_q[ufc_pkg::FC_TX_LVL_LO +: 2]);
        end
    end

    // R1: single enable for both
    assign FIFO_EN_O = fifo_ctrl_q[ufc_pkg::FC_ENABLE];
    assign RX_FLUSH_O = rx_flush_q;
    assign TX_FLUSH_O = tx_flush_q;
    assign RX_TRIG_O = rx_trig;
    assign TX_TRIG_O = tx_trig;

    ////////////////////////////////////////////////////////////////////
    // Receive ready is a level: follows the count with no latch
    // R5: reached threshold
    // R10: withdrawn below threshold
    assign rx_ready = FIFO_EN_O && (rx_cnt >= rx_trig);
    assign RX_READY_IRQ_O = rx_ready;

    // Transmit empty is an event on falling below threshold
    // R7: below threshold
    assign tx_below = FIFO_EN_O && (tx_cnt < tx_trig);

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_empty_prev_q <= 1'b0;
        end else begin
            tx_empty_prev_q <= tx_below;
        end
    end

    // Status bit 0 mirrors rx ready; bit 1 sticky, set wins over clear
    // R11: cleared by read or write
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q[ufc_pkg::IRQ_RX_READY] <= rx_ready;
            if (tx_below && !tx_empty_prev_q) begin
                irq_stat_q[ufc_pkg::IRQ_TX_EMPTY] <= 1'b1;
            end else if (rd_stat || TX_HOLD_WR_I ||
                (WR_I && hit(ADDR_I, ufc_pkg::OFS_IRQ_STAT) &&
                 WDATA_I[ufc_pkg::IRQ_TX_EMPTY])) begin
                irq_stat_q[ufc_pkg::IRQ_TX_EMPTY] <= 1'b0;
            end
        end
    end
    assign TX_EMPTY_IRQ_O = irq_stat_q[ufc_pkg::IRQ_TX_EMPTY];

    // Mask register
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask_q <= ufc_pkg::IRQ_MASK_RST;
        end else if (WR_I && hit(ADDR_I, ufc_pkg::OFS_IRQ_MASK)) begin
            irq_mask_q <= WDATA_I[1:0];
        end
    end

    // Level interrupt; rx bit read directly so it drops at once
    assign IRQ_O = |({irq_stat_q[1], rx_ready} & irq_mask_q);

    ////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                ufc_pkg::OFS_FIFO_CTRL: rdata_q <= fifo_ctrl_q;
                ufc_pkg::OFS_RX_LVL: rdata_q <= rx_lvl_q;
                ufc_pkg::OFS_TX_LVL: rdata_q <= tx_lvl_q;
                ufc_pkg::OFS_FLOW_LO: rdata_q <= flow_lo_q;
                ufc_pkg::OFS_FLOW_HI: rdata_q <= flow_hi_q;
                ufc_pkg::OFS_IRQ_STAT:
                    rdata_q <= {6'h00, irq_stat_q[1], rx_ready};
                ufc_pkg::OFS_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
                ufc_pkg::OFS_STATUS: rdata_q <= {7'h00, override};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign RDATA_O = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rx_flush_wr;
        wr_fc && WDATA_I[ufc_pkg::FC_RX_RST];
    endsequence

    sequence s_tx_flush_wr;
        wr_fc && WDATA_I[ufc_pkg::FC_TX_RST];
    endsequence

    sequence s_tx_fall;
        tx_below && !tx_empty_prev_q;
    endsequence

    // A lone flush write; back to back flush writes stretch the pulse
    a_rx_flush_pulse: assert property ( // R2
        s_rx_flush_wr ##1 !(wr_fc && WDATA_I[ufc_pkg::FC_RX_RST])
        |-> RX_FLUSH_O ##1 !RX_FLUSH_O)
        else $error("rx flush pulse wrong");
    a_tx_flush_pulse: assert property ( // R3
        s_tx_flush_wr ##1 !(wr_fc && WDATA_I[ufc_pkg::FC_TX_RST])
        |-> TX_FLUSH_O ##1 !TX_FLUSH_O)
        else $error("tx flush pulse wrong");
    a_flush_reads_zero: assert property ( // R12
        RD_I && hit(ADDR_I, ufc_pkg::OFS_FIFO_CTRL) |=> RDATA_O[3:1] == 3'h0)
        else $error("self clearing bits read back set");
    // First edge out of reset still shows the cleared state
    a_reset_values: assert property ( // R4
        $past(RST_I) |-> !FIFO_EN_O && !RX_FLUSH_O && !TX_FLUSH_O &&
            !TX_EMPTY_IRQ_O && RDATA_O == 8'h00)
        else $error("outputs not cleared by reset");
    a_enable_follows: assert property ( // R1
        wr_fc |=> FIFO_EN_O == $past(WDATA_I[ufc_pkg::FC_ENABLE]))
        else $error("enable not taken");
    a_rx_decode_low: assert property ( // R6
        !override && fifo_ctrl_q[7:6] == 2'h0 |-> RX_TRIG_O == 8'h08)
        else $error("rx decode wrong");
    a_rx_decode_table: assert property ( // R6
        !override && fifo_ctrl_q[7:6] == 2'h3 |-> RX_TRIG_O == 8'h1c)
        else $error("rx decode wrong");
    a_tx_decode_low: assert property ( // R8
        !override && fifo_ctrl_q[5:4] == 2'h0 |-> TX_TRIG_O == 8'h10)
        else $error("tx decode wrong");
    a_tx_decode_table: assert property ( // R8
        !override && fifo_ctrl_q[5:4] == 2'h1 |-> TX_TRIG_O == 8'h08)
        else $error("tx decode wrong");
    a_tx_decode_top: assert property ( // R8
        !override && fifo_ctrl_q[5:4] == 2'h3 |-> TX_TRIG_O == 8'h1e)
        else $error("tx decode wrong");
    a_override_levels: assert property ( // R9
        override |-> RX_TRIG_O == rx_lvl_q && TX_TRIG_O == tx_lvl_q)
        else $error("override not applied");
    a_rx_ready_reach: assert property ( // R5
        FIFO_EN_O && rx_cnt >= RX_TRIG_O |-> RX_READY_IRQ_O)
        else $error("rx ready not raised");
    a_rx_ready_drop: assert property ( // R10
        rx_cnt < RX_TRIG_O |-> !RX_READY_IRQ_O)
        else $error("rx ready not withdrawn");
    a_rx_irq_masked: assert property ( // R5
        irq_mask_q[ufc_pkg::IRQ_RX_READY] && RX_READY_IRQ_O |-> IRQ_O)
        else $error("rx ready not on interrupt line");
    a_tx_empty_set: assert property ( // R7
        s_tx_fall |=> TX_EMPTY_IRQ_O)
        else $error("tx empty not raised");
    a_tx_empty_clear: assert property ( // R11
        TX_HOLD_WR_I && !(tx_below && !tx_empty_prev_q) |=> !TX_EMPTY_IRQ_O)
        else $error("tx empty not cleared");
    a_reserved_bit: assert property ( // R13
        wr_fc && WDATA_I[3] |=> !fifo_ctrl_q[3])
        else $error("reserved bit stored");

endmodule // ufc_fifo_ctrl

// ### ufc_fifo_model.sv
/*
 * Behavioural receive and transmit FIFO fill counters beside the block.
 * Assumes the bench loads counts with a one-cycle strobe on MCLK_I.
 */
module ufc_fifo_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rx_flush_i,
    input wire logic tx_flush_i,
    input wire logic load_i,
    input wire logic [7:0] rx_load_i,
    input wire logic [7:0] tx_load_i,
    output logic [7:0] rx_count_o,
    output logic [7:0] tx_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flush wins over a load in the same cycle, as a real FIFO would
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_count_o <= 8'h00;
            tx_count_o <= 8'h00;
        end else begin
            if (load_i) begin
                rx_count_o <= rx_load_i;
                tx_count_o <= tx_load_i;
            end
            if (rx_flush_i) rx_count_o <= 8'h00;
            if (tx_flush_i) tx_count_o <= 8'h00;
        end
    end
endmodule // ufc_fifo_model

// ### ufc_pkg.sv
/*
 * Package for the UART FIFO control block: register offsets, field
 * positions, reset values and trigger level decodes.
 * Assumes a plain strobed register port with 8-bit data.
 */
package ufc_pkg;
    // Register offsets (byte index on the register port)
    localparam logic [3:0] OFS_FIFO_CTRL = 4'h0;
    localparam logic [3:0] OFS_RX_LVL = 4'h1;
    localparam logic [3:0] OFS_TX_LVL = 4'h2;
    localparam logic [3:0] OFS_FLOW_LO = 4'h3;
    localparam logic [3:0] OFS_FLOW_HI = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    // Fifo control fields
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_RST = 1;
    localparam int FC_TX_RST = 2;
    localparam int FC_TX_LVL_LO = 4;
    localparam int FC_RX_LVL_LO = 6;
    // Interrupt status bits
    localparam int IRQ_RX_READY = 0;
    localparam int IRQ_TX_EMPTY = 1;
    // Reset values
    localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
    localparam logic [7:0] LVL_RST = 8'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    // Trigger levels in 32-byte mode
    localparam logic [7:0] RX_TRIG_0 = 8'h08;
    localparam logic [7:0] RX_TRIG_1 = 8'h10;
    localparam logic [7:0] RX_TRIG_2 = 8'h18;
    localparam logic [7:0] RX_TRIG_3 = 8'h1c;
    localparam logic [7:0] TX_TRIG_0 = 8'h10;
    localparam logic [7:0] TX_TRIG_1 = 8'h08;
    localparam logic [7:0] TX_TRIG_2 = 8'h18;
    localparam logic [7:0] TX_TRIG_3 = 8'h1e;
endpackage : ufc_pkg
